// ==== core/xcvr_map.svh ====
// offsets, field positions, reset values and timing counts of the
// transceiver mode-control block; included by bare name
`ifndef XCVR_MAP_SVH
`define XCVR_MAP_SVH

`define CLK_MHZ 100

// detection and hold times in ns
`define ACT_DET_NS 100
`define IDLE_DET_NS 200
`define GTS_HOLD_NS 50000

// least times, rounded up to whole cycles
`define ACT_DET_CYC ((`ACT_DET_NS * `CLK_MHZ + 999) / 1000)
`define IDLE_DET_CYC ((`IDLE_DET_NS * `CLK_MHZ + 999) / 1000)
`define GTS_HOLD_CYC ((`GTS_HOLD_NS * `CLK_MHZ + 999) / 1000)

// register byte offsets
`define REG_STATUS 4'h0
`define REG_CTRL 4'h4
`define REG_FLAG_CLR 4'h8

// control fields
`define CTRL_RESET 2'h0
`define CTRL_TX_INHIBIT 0
`define CTRL_DIAG_EN 1

// flag clear fields
`define CLR_ERROR 0
`define CLR_POWER_ON 1

// host pin defaults when undriven: only transmit gate pulls up
`define PIN_DEFAULT 5'h02

`define DIAG_BITS 4'h8

`endif

// ==== core/xcvr_pkg.sv ====
// types shared by the transceiver mode-control files
// assumes nothing beyond a SystemVerilog compiler
package xcvr_pkg;

    typedef enum logic [4:0] {
        MODE_NORMAL = 5'h01,
        MODE_RECV_ONLY = 5'h02,
        MODE_STANDBY = 5'h04,
        MODE_GOTO_SLEEP = 5'h08,
        MODE_SLEEP = 5'h10
    } mode_t;

    typedef struct packed {
        logic xmit_data;
        logic enable;
        logic standby_select_low;
        logic transmit_gate_low;
        logic guardian_gate;
    } pins_t;

    typedef struct packed {
        logic above_act;
        logic above_high;
        logic below_low;
    } sense_t;

    typedef struct packed {
        logic io_low;
        logic battery_low;
        logic core_low;
    } supply_t;

endpackage : xcvr_pkg

// ==== core/activity_detect.sv ====
// bus activity / idle detector on the synchronised activity comparator
// assumes synchronous inputs and an active-low reset already synchronised
`include "xcvr_map.svh"

module activity_detect (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic run_in,
    input wire logic above_act_in,
    output logic active_out
);

    localparam logic [7:0] ACT_CYC = 8'(`ACT_DET_CYC);
    localparam logic [7:0] IDLE_CYC = 8'(`IDLE_DET_CYC);

    logic [7:0] cnt_ff;
    logic active_ff;

    // counts cycles the comparator disagrees with the current state
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_ff <= 8'h00;
        end else if (!run_in || above_act_in == active_ff) begin
            cnt_ff <= 8'h00;
        end else if (cnt_ff != 8'hff) begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            active_ff <= 1'b0;
        end else if (!run_in) begin
            active_ff <= 1'b0;
        end else if (!active_ff && above_act_in
                     && cnt_ff + 8'h01 >= ACT_CYC) begin
            active_ff <= 1'b1;
        end else if (active_ff && !above_act_in
                     && cnt_ff + 8'h01 >= IDLE_CYC) begin
            active_ff <= 1'b0;
        end
    end

    assign active_out = active_ff;

endmodule : activity_detect

// ==== core/xcvr_mode_ctrl.sv ====
// mode control and status logic of a differential bus node transceiver
// assumes analog comparators and supply detectors arrive as async levels
// Functional notes
// - Five modes: normal, receive-only, standby, go-to-sleep, sleep.
// - Standby-select and enable pins pick the mode: 11,10,00,01.
// - Mode follows pins unless an undervoltage overrides it.
// - Activity held long enough drives activity low, releases data.
// - After activity, data follows high and low thresholds.
// - Quiet bus long enough declares idle, activity and data high.
// - With supplies in range, fault output is low while error set.
// - Fault output also shifts out diagnostic bits to the host.
// - Standby-select rising sets wake; entering normal clears it.
// - Wake flag setting clears all three undervoltage flags.
// - Leaving go-to-sleep early follows pins, no sleep.
// - Go-to-sleep past hold limit enters sleep, clears wake.
// - Transmit gate high disables transmitter; pulls up undriven.
// - Guardian gate low disables transmitter unconditionally.
// - Data, enable, standby-select pull down when undriven.
// - Normal mode enabled: data high drives plus high, minus low.
// - Receive-only keeps transmitter off whatever the gates say.
// - Standby: activity and data low while wake set, else high.
// - Core undervoltage forces standby regardless of pins, from any mode but sleep.
//
// Local design decisions: the register offsets and the Wishbone register port.
`include "xcvr_map.svh"

module xcvr_mode_ctrl #(
    parameter int GTS_HOLD_CYC = `GTS_HOLD_CYC
) (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    // host pins, with per-pin driven flags
    input wire logic XMIT_DATA_IN,
    input wire logic ENABLE_IN,
    input wire logic STANDBY_SELECT_LOW_IN,
    input wire logic TRANSMIT_GATE_LOW_IN,
    input wire logic GUARDIAN_GATE_IN,
    input wire logic [4:0] HOST_DRIVEN_IN,
    // bus comparators and line drivers
    input wire logic BUS_ABOVE_ACT_IN,
    input wire logic BUS_ABOVE_HIGH_IN,
    input wire logic BUS_BELOW_LOW_IN,
    output logic BUS_PLUS_OUT,
    output logic BUS_PLUS_OE_OUT,
    output logic BUS_MINUS_OUT,
    output logic BUS_MINUS_OE_OUT,
    // supply detectors and error source
    input wire logic IO_SUPPLY_LOW_IN,
    input wire logic BATTERY_LOW_IN,
    input wire logic CORE_SUPPLY_LOW_IN,
    input wire logic ERROR_DETECT_IN,
    // host status outputs
    output logic RECV_DATA_OUT,
    output logic BUS_ACTIVITY_LOW_OUT,
    output logic FAULT_INDICATOR_LOW_OUT,
    output logic REGULATOR_SWITCH_OUT,
    output logic REGULATOR_SWITCH_OE_OUT,
    // wishbone slave
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [3:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT
);

    localparam logic [15:0] HOLD_LIM = 16'(GTS_HOLD_CYC);

    logic [1:0] rst_sync_ff;
    logic rst_n;
    logic [11:0] meta_ff;
    logic [11:0] sync_ff;
    xcvr_pkg::pins_t pins_raw;
    xcvr_pkg::pins_t pins;
    xcvr_pkg::sense_t sense;
    xcvr_pkg::supply_t supply;
    logic error_det;
    logic prev_standby_select_low_ff;
    logic prev_en_ff;
    logic [1:0] applied_ff;
    xcvr_pkg::mode_t mode_ff;
    xcvr_pkg::mode_t nxt_mode;
    xcvr_pkg::mode_t pin_mode;
    logic [15:0] hold_ff;
    logic hold_done;
    logic wake_ff;
    logic wake_set;
    xcvr_pkg::supply_t uv_ff;
    logic error_ff;
    logic power_on_flag_ff;
    logic [1:0] ctrl_ff;
    logic normal_pwr;
    logic active;
    logic rxd_ff;
    logic tx_on;
    logic supply_ok;
    logic [3:0] diag_idx_ff;
    logic [7:0] diag_word_ff;
    logic [7:0] diag_snap;
    logic en_edge;
    logic bus_req;
    logic wr_req;
    logic [31:0] status_word;
    logic [31:0] rd_word;

    // reset release through two flops
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // undriven pins take their pull level
    assign pins_raw = {XMIT_DATA_IN, ENABLE_IN, STANDBY_SELECT_LOW_IN,
                       TRANSMIT_GATE_LOW_IN, GUARDIAN_GATE_IN};

    // two-flop synchronisers for every async level
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= {7'h00, `PIN_DEFAULT};
            sync_ff <= {7'h00, `PIN_DEFAULT};
        end else begin
            meta_ff <= {BUS_ABOVE_ACT_IN, BUS_ABOVE_HIGH_IN,
                        BUS_BELOW_LOW_IN, IO_SUPPLY_LOW_IN,
                        BATTERY_LOW_IN, CORE_SUPPLY_LOW_IN,
                        ERROR_DETECT_IN,
                        (pins_raw & HOST_DRIVEN_IN)
                        | (`PIN_DEFAULT & ~HOST_DRIVEN_IN)};
            sync_ff <= meta_ff;
        end
    end
    assign pins = sync_ff[4:0];
    assign error_det = sync_ff[5];
    assign supply = sync_ff[8:6];
    assign sense = sync_ff[11:9];

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            prev_standby_select_low_ff <= 1'b0;
            prev_en_ff <= 1'b0;
        end else begin
            prev_standby_select_low_ff <= pins.standby_select_low;
            prev_en_ff <= pins.enable;
        end
    end
    assign wake_set = pins.standby_select_low & ~prev_standby_select_low_ff;
    assign en_edge = pins.enable ^ prev_en_ff;

    // pin decode of the requested mode
    always_comb begin
        unique case ({pins.standby_select_low, pins.enable})
            2'b11: pin_mode = xcvr_pkg::MODE_NORMAL;
            2'b10: pin_mode = xcvr_pkg::MODE_RECV_ONLY;
            2'b01: pin_mode = xcvr_pkg::MODE_GOTO_SLEEP;
            2'b00: pin_mode = xcvr_pkg::MODE_STANDBY;
        endcase
    end

    assign hold_done = hold_ff > HOLD_LIM;

    // next mode: undervoltage first, then hold expiry, then pins
    always_comb begin
        nxt_mode = mode_ff;
        if (uv_ff.io_low || uv_ff.battery_low) begin
            nxt_mode = xcvr_pkg::MODE_SLEEP;
        end else if (uv_ff.core_low
                     && mode_ff != xcvr_pkg::MODE_SLEEP) begin
            nxt_mode = xcvr_pkg::MODE_STANDBY;
        end else if (mode_ff == xcvr_pkg::MODE_GOTO_SLEEP
                     && hold_done) begin
            nxt_mode = xcvr_pkg::MODE_SLEEP;
        end else if ({pins.standby_select_low, pins.enable}
                     != applied_ff) begin
            if (mode_ff == xcvr_pkg::MODE_SLEEP
                && !pins.standby_select_low) begin
                nxt_mode = xcvr_pkg::MODE_SLEEP;
            end else begin
                nxt_mode = pin_mode;
            end
        end
    end

    // mode state register
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff <= xcvr_pkg::MODE_STANDBY;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // last pin pair acted on; standby pair while overridden, so the
    // pins are applied again once a wake clears the flags
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            applied_ff <= 2'b00;
        end else if (uv_ff.io_low || uv_ff.battery_low
                     || uv_ff.core_low) begin
            applied_ff <= 2'b00;
        end else begin
            applied_ff <= {pins.standby_select_low, pins.enable};
        end
    end

    // go-to-sleep hold timer, saturating
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            hold_ff <= 16'h0000;
        end else if (mode_ff != xcvr_pkg::MODE_GOTO_SLEEP) begin
            hold_ff <= 16'h0000;
        end else if (hold_ff != 16'hffff) begin
            hold_ff <= hold_ff + 16'h0001;
        end
    end

    // wake flag
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            wake_ff <= 1'b0;
        end else if (nxt_mode == xcvr_pkg::MODE_NORMAL) begin
            wake_ff <= 1'b0;
        end else if (wake_set) begin
            wake_ff <= 1'b1;
        end else if (mode_ff == xcvr_pkg::MODE_GOTO_SLEEP
                     && nxt_mode == xcvr_pkg::MODE_SLEEP) begin
            wake_ff <= 1'b0;
        end
    end

    // undervoltage flags: detection wins over the wake clear
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            uv_ff <= 3'h0;
        end else begin
            uv_ff <= (uv_ff & {3{~wake_set}}) | supply;
        end
    end

    assign bus_req = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
    assign wr_req = bus_req & WB_WE_IN & WB_SEL_IN[0];

    // error flag: sticky, software clear, set wins
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            error_ff <= 1'b0;
        end else if (error_det) begin
            error_ff <= 1'b1;
        end else if (wr_req && WB_ADR_IN == `REG_FLAG_CLR
                     && WB_DAT_IN[`CLR_ERROR]) begin
            error_ff <= 1'b0;
        end
    end

    // power-on flag: set by reset, cleared on leaving normal
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            power_on_flag_ff <= 1'b1;
        end else if (mode_ff == xcvr_pkg::MODE_NORMAL
                     && nxt_mode != xcvr_pkg::MODE_NORMAL) begin
            power_on_flag_ff <= 1'b0;
        end else if (wr_req && WB_ADR_IN == `REG_FLAG_CLR
                     && WB_DAT_IN[`CLR_POWER_ON]) begin
            power_on_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= `CTRL_RESET;
        end else if (wr_req && WB_ADR_IN == `REG_CTRL) begin
            ctrl_ff <= WB_DAT_IN[1:0];
        end
    end

    assign normal_pwr = mode_ff == xcvr_pkg::MODE_NORMAL
                        || mode_ff == xcvr_pkg::MODE_RECV_ONLY;

    activity_detect u_act (
        .clk_in(CLK_IN),
        .rst_n_in(rst_n),
        .run_in(normal_pwr),
        .above_act_in(sense.above_act),
        .active_out(active)
    );

    // receive data and activity outputs
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            rxd_ff <= 1'b1;
            BUS_ACTIVITY_LOW_OUT <= 1'b1;
        end else if (!normal_pwr) begin
            rxd_ff <= ~wake_ff;
            BUS_ACTIVITY_LOW_OUT <= ~wake_ff;
        end else if (!active) begin
            rxd_ff <= 1'b1;
            BUS_ACTIVITY_LOW_OUT <= 1'b1;
        end else begin
            BUS_ACTIVITY_LOW_OUT <= 1'b0;
            if (sense.above_high) begin
                rxd_ff <= 1'b1;
            end else if (sense.below_low) begin
                rxd_ff <= 1'b0;
            end
        end
    end
    assign RECV_DATA_OUT = rxd_ff;

    // transmitter gating
    assign tx_on = mode_ff == xcvr_pkg::MODE_NORMAL
                   && pins.guardian_gate
                   && !pins.transmit_gate_low
                   && !ctrl_ff[`CTRL_TX_INHIBIT];

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            BUS_PLUS_OUT <= 1'b0;
            BUS_MINUS_OUT <= 1'b0;
            BUS_PLUS_OE_OUT <= 1'b0;
            BUS_MINUS_OE_OUT <= 1'b0;
        end else begin
            BUS_PLUS_OUT <= pins.xmit_data;
            BUS_MINUS_OUT <= ~pins.xmit_data;
            BUS_PLUS_OE_OUT <= tx_on;
            BUS_MINUS_OE_OUT <= tx_on;
        end
    end

    // regulator switch high, floats in sleep
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            REGULATOR_SWITCH_OUT <= 1'b1;
            REGULATOR_SWITCH_OE_OUT <= 1'b1;
        end else begin
            REGULATOR_SWITCH_OUT <= 1'b1;
            REGULATOR_SWITCH_OE_OUT <= mode_ff != xcvr_pkg::MODE_SLEEP;
        end
    end

    // serial diagnostic readout stepped by enable edges
    assign diag_snap = {uv_ff, power_on_flag_ff, wake_ff, error_ff, active,
                        tx_on};

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            diag_idx_ff <= 4'h0;
            diag_word_ff <= 8'h00;
        end else if (!normal_pwr || !ctrl_ff[`CTRL_DIAG_EN]) begin
            diag_idx_ff <= 4'h0;
        end else if (en_edge) begin
            if (diag_idx_ff == 4'h0) begin
                diag_word_ff <= diag_snap;
            end
            if (diag_idx_ff == `DIAG_BITS) begin
                diag_idx_ff <= 4'h0;
            end else begin
                diag_idx_ff <= diag_idx_ff + 4'h1;
            end
        end
    end

    assign supply_ok = !supply.io_low
                       && (!supply.core_low || !supply.battery_low);

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            FAULT_INDICATOR_LOW_OUT <= 1'b1;
        end else if (!supply_ok) begin
            FAULT_INDICATOR_LOW_OUT <= 1'b1;
        end else if (diag_idx_ff == 4'h0) begin
            FAULT_INDICATOR_LOW_OUT <= ~error_ff;
        end else begin
            FAULT_INDICATOR_LOW_OUT <=
                ~diag_word_ff[3'(diag_idx_ff - 4'h1)];
        end
    end

    // register read mux
    assign status_word = {19'h00000, tx_on, active, error_ff, uv_ff,
                          power_on_flag_ff, wake_ff, mode_ff};

    always_comb begin
        unique case (WB_ADR_IN)
            `REG_STATUS: rd_word = status_word;
            `REG_CTRL: rd_word = {30'h00000000, ctrl_ff};
            default: rd_word = 32'h00000000;
        endcase
    end

    // single-cycle wishbone answer
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            WB_ACK_OUT <= 1'b0;
            WB_DAT_OUT <= 32'h00000000;
        end else begin
            WB_ACK_OUT <= bus_req;
            if (bus_req && !WB_WE_IN) begin
                WB_DAT_OUT <= rd_word;
            end
        end
    end

endmodule : xcvr_mode_ctrl

// ==== verif/xcvr_mode_ctrl_props.sv ====
// assertions on the ports of the transceiver mode-control top
// assumes it is bound onto xcvr_mode_ctrl, one clock domain
module xcvr_mode_ctrl_props (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    // watched inputs
    input wire logic TRANSMIT_GATE_LOW_IN,
    input wire logic GUARDIAN_GATE_IN,
    input wire logic IO_SUPPLY_LOW_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    // watched outputs
    input wire logic BUS_PLUS_OUT,
    input wire logic BUS_PLUS_OE_OUT,
    input wire logic BUS_MINUS_OUT,
    input wire logic BUS_MINUS_OE_OUT,
    input wire logic RECV_DATA_OUT,
    input wire logic BUS_ACTIVITY_LOW_OUT,
    input wire logic FAULT_INDICATOR_LOW_OUT,
    input wire logic REGULATOR_SWITCH_OE_OUT,
    input wire logic WB_ACK_OUT
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    sequence s_req;
        WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
    endsequence
    sequence s_guard_low;
        !GUARDIAN_GATE_IN [*5];
    endsequence
    a_guard_kills_tx: assert property (s_guard_low |-> !BUS_PLUS_OE_OUT)
        else $error("tx on with guardian low");
    a_gate_kills_tx: assert property (
        TRANSMIT_GATE_LOW_IN [*5] |-> !BUS_PLUS_OE_OUT)
        else $error("tx on with gate high");
    a_line_opposite: assert property (
        BUS_PLUS_OE_OUT |-> BUS_PLUS_OUT != BUS_MINUS_OUT)
        else $error("lines not opposite");
    a_oe_paired: assert property (BUS_PLUS_OE_OUT == BUS_MINUS_OE_OUT)
        else $error("line enables differ");
    a_idle_rx_high: assert property (
        BUS_ACTIVITY_LOW_OUT |-> RECV_DATA_OUT)
        else $error("data low while idle");
    a_sleep_quiet: assert property (
        !REGULATOR_SWITCH_OE_OUT |-> !BUS_PLUS_OE_OUT)
        else $error("tx on in sleep");
    a_fault_supply: assert property (
        IO_SUPPLY_LOW_IN [*5] |-> FAULT_INDICATOR_LOW_OUT)
        else $error("fault low with supply out");
    a_ack_one: assert property (s_req |=> WB_ACK_OUT)
        else $error("no ack after request");
    a_ack_drops: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
        else $error("ack held two cycles");
endmodule : xcvr_mode_ctrl_props

bind xcvr_mode_ctrl xcvr_mode_ctrl_props u_xcvr_mode_ctrl_props (
    .CLK_IN, .RST_N_IN, .TRANSMIT_GATE_LOW_IN, .GUARDIAN_GATE_IN,
    .IO_SUPPLY_LOW_IN, .WB_CYC_IN, .WB_STB_IN, .BUS_PLUS_OUT,
    .BUS_PLUS_OE_OUT, .BUS_MINUS_OUT, .BUS_MINUS_OE_OUT, .RECV_DATA_OUT,
    .BUS_ACTIVITY_LOW_OUT, .FAULT_INDICATOR_LOW_OUT,
    .REGULATOR_SWITCH_OE_OUT, .WB_ACK_OUT);

// ==== verif/host_pins_model.sv ====
// host-side model that drives the standby-select and enable pins
// assumes requests as {standby_select_low, enable}, one clock domain
module host_pins_model #(
    parameter int EN_DET_CYC = 4
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // requested pin pair
    input wire logic [1:0] req_in,
    // pins and status
    output logic standby_select_low_out,
    output logic enable_out,
    output logic settled_out
);
    timeunit 1ns;
    timeprecision 100ps;
    int wait_ff;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            standby_select_low_out <= 1'b0;
            enable_out <= 1'b0;
            wait_ff <= 0;
        end else if (enable_out && standby_select_low_out
                     && req_in == 2'b00) begin
            // enable falls first, select follows later
            enable_out <= 1'b0;
            wait_ff <= EN_DET_CYC;
        end else if (wait_ff != 0) begin
            wait_ff <= wait_ff - 1;
        end else begin
            standby_select_low_out <= req_in[1];
            enable_out <= req_in[0];
        end
    end
    assign settled_out = ({standby_select_low_out, enable_out} == req_in)
        && (wait_ff == 0);
endmodule : host_pins_model

// ==== verif/tb_top.sv ====
// self-checking bench of the transceiver mode-control block
// assumes core/ on the include path and the checker bound in
`include "xcvr_map.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_n = 0, xd = 0, gate = 1, guard = 0, act = 0;
    logic hi = 0, lo = 0, io_low = 0, bat_low = 0, core_low = 0, err = 0;
    logic cyc = 0, stb = 0, we = 0;
    logic [3:0] adr = 4'h0, sel = 4'hf;
    logic [4:0] drv = 5'h1f;
    logic [31:0] wdat = 32'h0, rd, rdat, v;
    logic [1:0] req = 2'b00;
    logic en, stbsel, settled, plus, plus_oe, minus, minus_oe, rxd;
    logic activity_low, fault_low, reg_oe, ack;
    int seed, n_mismatch = 0, num_checks = 0;
    xcvr_pkg::mode_t m_mode = xcvr_pkg::MODE_STANDBY;
    xcvr_pkg::mode_t tbl [4] = '{xcvr_pkg::MODE_STANDBY,
        xcvr_pkg::MODE_GOTO_SLEEP, xcvr_pkg::MODE_RECV_ONLY,
        xcvr_pkg::MODE_NORMAL};
    logic m_wake = 0, m_uv = 0, m_stb = 0;
    always #5 clk = ~clk;
    host_pins_model u_host_pins_model (.clk_in(clk), .rst_n_in(rst_n),
        .req_in(req), .standby_select_low_out(stbsel), .enable_out(en),
        .settled_out(settled));
    xcvr_mode_ctrl #(.GTS_HOLD_CYC(20)) u_xcvr_mode_ctrl (.CLK_IN(clk),
        .RST_N_IN(rst_n), .XMIT_DATA_IN(xd), .ENABLE_IN(en),
        .STANDBY_SELECT_LOW_IN(stbsel), .TRANSMIT_GATE_LOW_IN(gate),
        .GUARDIAN_GATE_IN(guard), .HOST_DRIVEN_IN(drv),
        .BUS_ABOVE_ACT_IN(act), .BUS_ABOVE_HIGH_IN(hi),
        .BUS_BELOW_LOW_IN(lo), .BUS_PLUS_OUT(plus),
        .BUS_PLUS_OE_OUT(plus_oe), .BUS_MINUS_OUT(minus),
        .BUS_MINUS_OE_OUT(minus_oe), .IO_SUPPLY_LOW_IN(io_low),
        .BATTERY_LOW_IN(bat_low), .CORE_SUPPLY_LOW_IN(core_low),
        .ERROR_DETECT_IN(err), .RECV_DATA_OUT(rxd),
        .BUS_ACTIVITY_LOW_OUT(activity_low),
        .FAULT_INDICATOR_LOW_OUT(fault_low), .REGULATOR_SWITCH_OUT(),
        .REGULATOR_SWITCH_OE_OUT(reg_oe), .WB_CYC_IN(cyc),
        .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
        .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack));
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic hang;
        n_mismatch++;
        $display("Error at %0t: wait ran out", $time);
        end_sim();
    endtask : hang
    task automatic wb(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) hang();
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic go(input logic [1:0] p);
        int n;
        n = 0;
        @(posedge clk);
        req <= p;
        @(posedge clk);
        while (settled !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) hang();
        repeat (6) @(posedge clk);
        if (p[1] && !m_stb) begin
            m_wake = 1'b1;
            m_uv = 1'b0;
        end
        if (!m_uv && !(m_mode == xcvr_pkg::MODE_SLEEP && !p[1])) begin
            m_mode = tbl[p];
        end
        if (m_mode == xcvr_pkg::MODE_NORMAL) m_wake = 1'b0;
        m_stb = p[1];
    endtask : go
    task automatic st;
        wb(1'b0, `REG_STATUS, 32'h0);
        chk({25'h0, rd[7], rd[5:0]}, {25'h0, m_uv, m_wake, m_mode});
    endtask : st
    initial begin
        seed = 78;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        wb(1'b0, `REG_STATUS, 32'h0);
        chk({25'h0, rd[6:0]}, 32'h44);
        wb(1'b1, `REG_CTRL, 32'h3);
        wb(1'b0, `REG_CTRL, 32'h0);
        chk(rd, 32'h3);
        wb(1'b1, `REG_CTRL, 32'h0);
        wb(1'b0, 4'hc, 32'h0);
        chk(rd, 32'h0);
        chk({30'h0, activity_low, rxd}, 32'h3);
        go(2'b10);
        st();
        go(2'b00);
        st();
        chk({30'h0, activity_low, rxd}, 32'h0);
        go(2'b11);
        st();
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            @(posedge clk);
            xd <= v[0];
            gate <= v[1];
            guard <= v[2] | i[0];
            repeat (5) @(posedge clk);
            v[2] = v[2] | i[0];
            chk({plus_oe, plus & plus_oe, minus & plus_oe}, {v[2] & ~v[1],
                v[2] & ~v[1] & v[0], v[2] & ~v[1] & ~v[0]});
        end
        gate <= 1'b0;
        guard <= 1'b1;
        drv <= 5'h1d;
        repeat (5) @(posedge clk);
        chk({31'h0, plus_oe}, 32'h0);
        drv <= 5'h1f;
        wb(1'b1, `REG_CTRL, 32'h1);
        repeat (2) @(posedge clk);
        chk({31'h0, plus_oe}, 32'h0);
        wb(1'b1, `REG_CTRL, 32'h0);
        act <= 1'b1;
        repeat (`ACT_DET_CYC - 2) @(posedge clk);
        act <= 1'b0;
        repeat (6) @(posedge clk);
        chk({31'h0, activity_low}, 32'h1);
        act <= 1'b1;
        hi <= 1'b1;
        repeat (`ACT_DET_CYC + 5) @(posedge clk);
        chk({30'h0, activity_low, rxd}, 32'h1);
        hi <= 1'b0;
        lo <= 1'b1;
        repeat (5) @(posedge clk);
        chk({31'h0, rxd}, 32'h0);
        act <= 1'b0;
        lo <= 1'b0;
        repeat (`IDLE_DET_CYC + 6) @(posedge clk);
        chk({30'h0, activity_low, rxd}, 32'h3);
        go(2'b00);
        st();
        go(2'b01);
        st();
        go(2'b00);
        st();
        go(2'b01);
        repeat (40) @(posedge clk);
        m_mode = xcvr_pkg::MODE_SLEEP;
        m_wake = 1'b0;
        st();
        chk({31'h0, reg_oe}, 32'h0);
        go(2'b00);
        st();
        go(2'b11);
        st();
        core_low <= 1'b1;
        repeat (8) @(posedge clk);
        core_low <= 1'b0;
        m_mode = xcvr_pkg::MODE_STANDBY;
        m_uv = 1'b1;
        st();
        go(2'b10);
        st();
        go(2'b00);
        go(2'b11);
        st();
        err <= 1'b1;
        @(posedge clk);
        err <= 1'b0;
        repeat (5) @(posedge clk);
        chk({31'h0, fault_low}, 32'h0);
        wb(1'b1, `REG_CTRL, 32'h2);
        go(2'b10);
        go(2'b11);
        chk({31'h0, fault_low}, 32'h1);
        wb(1'b1, `REG_CTRL, 32'h0);
        wb(1'b1, `REG_FLAG_CLR, 32'h1);
        repeat (3) @(posedge clk);
        chk({31'h0, fault_low}, 32'h1);
        err <= 1'b1;
        @(posedge clk);
        err <= 1'b0;
        io_low <= 1'b1;
        repeat (8) @(posedge clk);
        chk({31'h0, fault_low}, 32'h1);
        m_mode = xcvr_pkg::MODE_SLEEP;
        st();
        end_sim();
    end
endmodule : tb_top
